// ### common/spkbyp_map.svh
`ifndef SPKBYP_MAP_SVH
`define SPKBYP_MAP_SVH

// Register addresses (page zero)
`define SPKBYP_ADDR_RSVD_A 8'h46
`define SPKBYP_ADDR_RSVD_B 8'h47
`define SPKBYP_ADDR_RSVD_C 8'h48
`define SPKBYP_ADDR_AMP_CTRL 8'h49
`define SPKBYP_ADDR_RSVD_D 8'h4A
`define SPKBYP_ADDR_RSVD_E 8'h4B
`define SPKBYP_ADDR_DITHER 8'h4C
`define SPKBYP_ADDR_RSVD_F 8'h4D
`define SPKBYP_ADDR_RSVD_G 8'h4E

// Amplifier control fields
`define SPKBYP_AMP_LGAIN_HI 7
`define SPKBYP_AMP_LGAIN_LO 6
`define SPKBYP_AMP_RGAIN_HI 5
`define SPKBYP_AMP_RGAIN_LO 4
`define SPKBYP_AMP_LEN_BIT 3
`define SPKBYP_AMP_REN_BIT 2
`define SPKBYP_AMP_BYP_BIT 1
`define SPKBYP_AMP_BOOT_BIT 0
`define SPKBYP_AMP_RESET 8'h00

// Dither control fields
`define SPKBYP_DITH_L_HI 7
`define SPKBYP_DITH_L_LO 4
`define SPKBYP_DITH_R_HI 3
`define SPKBYP_DITH_R_LO 0
`define SPKBYP_DITH_RESET 8'h00

// Dither step and reserved read value
`define SPKBYP_DITH_STEP_MV 8'h0F
`define SPKBYP_DITH_MIN_MV 8'h0F
`define SPKBYP_DITH_MAX_MV 8'h69
`define SPKBYP_RDATA_RESET 8'h00
`define SPKBYP_RSVD_READ 8'h00

`endif

// ### common/spkbyp_pkg.sv
`default_nettype none
package spkbyp_pkg;
  typedef logic [7:0] spkbyp_byte_t;
  typedef logic [1:0] spkbyp_gain_t;
  typedef logic [3:0] spkbyp_dith_t;
  typedef logic [7:0] spkbyp_mv_t;
endpackage : spkbyp_pkg
`default_nettype wire

// ### verilog/spkbyp_gain_dec.sv
`timescale 1ns/1ps
`default_nettype none
`include "spkbyp_map.svh"
module spkbyp_gain_dec
  import spkbyp_pkg::*;
(
  input wire spkbyp_gain_t code_i,
  output logic [4:0] gain_db_o
);
  // Steps of 6 dB: 0, 6, 12, 18
  always_comb begin
    unique case (code_i)
      2'h0: gain_db_o = 5'h00;
      2'h1: gain_db_o = 5'h06;
      2'h2: gain_db_o = 5'h0C;
      2'h3: gain_db_o = 5'h12;
    endcase
  end
endmodule : spkbyp_gain_dec
`default_nettype wire

// ### verilog/spkbyp_dith_dec.sv
`timescale 1ns/1ps
`default_nettype none
`include "spkbyp_map.svh"
module spkbyp_dith_dec
  import spkbyp_pkg::*;
(
  input wire spkbyp_dith_t code_i,
  output logic enable_o,
  output logic negative_o,
  output spkbyp_mv_t mag_mv_o
);
  logic [10:0] prod;
  // Sign-magnitude: top bit sign, low three bits magnitude
  always_comb begin
    prod = 11'(code_i[2:0]) * 11'(`SPKBYP_DITH_STEP_MV);
    enable_o = (code_i[2:0] != 3'h0);
    negative_o = code_i[3] & enable_o;
    mag_mv_o = prod[7:0];
  end
endmodule : spkbyp_dith_dec
`default_nettype wire

// ### verilog/spkbyp_regs.sv
// How it works
// - Bits 7-6 set left gain 0-18 dB
// - Bits 5-4 set right gain likewise
// - Bit 3 write enables left channel
// - Bit 2 write enables right channel
// - Bit 1 write switches bypass on
// - Bit 0 runs bypass bootstrap clock
// - Amplifier register resets to all zero
// - Left dither sign-magnitude, 15 mV steps
// - Right dither same encoding, resets disabled
// - Magnitude 111 is 105, 001 is 15
// - Reserved addresses read zero; host never writes
`timescale 1ns/1ps
`default_nettype none
`include "spkbyp_map.svh"
module spkbyp_regs
  import spkbyp_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire spkbyp_byte_t addr_i,
  input wire spkbyp_byte_t wdata_i,
  output spkbyp_byte_t rdata_o,
  output logic rvalid_o,
  output logic [4:0] left_gain_db_o,
  output logic [4:0] right_gain_db_o,
  output spkbyp_gain_t left_gain_code_o,
  output spkbyp_gain_t right_gain_code_o,
  output logic left_amp_en_o,
  output logic right_amp_en_o,
  output logic bypass_sw_en_o,
  output logic boot_clk_en_o,
  output logic left_dith_en_o,
  output logic left_dith_neg_o,
  output spkbyp_mv_t left_dith_mv_o,
  output logic right_dith_en_o,
  output logic right_dith_neg_o,
  output spkbyp_mv_t right_dith_mv_o
);
  spkbyp_byte_t amp_q, amp_d;
  spkbyp_byte_t dith_q, dith_d;
  spkbyp_byte_t rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;

  // Register writes; reserved addresses ignore writes
  always_comb begin
    amp_d = amp_q;
    dith_d = dith_q;
    if (wr_en_i) begin
      if (addr_i == `SPKBYP_ADDR_AMP_CTRL) begin
        amp_d = wdata_i;
      end
      if (addr_i == `SPKBYP_ADDR_DITHER) begin
        dith_d = wdata_i;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      amp_q <= `SPKBYP_AMP_RESET;
      dith_q <= `SPKBYP_DITH_RESET;
    end else begin
      amp_q <= amp_d;
      dith_q <= dith_d;
    end
  end

  // Read path; write-only bits read back as zero
  always_comb begin
    rvalid_d = rd_en_i;
    rdata_d = `SPKBYP_RSVD_READ;
    if (rd_en_i) begin
      if (addr_i == `SPKBYP_ADDR_AMP_CTRL) begin
        rdata_d = {amp_q[`SPKBYP_AMP_LGAIN_HI:`SPKBYP_AMP_RGAIN_LO], 3'h0, amp_q[`SPKBYP_AMP_BOOT_BIT]};
      end else if (addr_i == `SPKBYP_ADDR_DITHER) begin
        rdata_d = dith_q;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rdata_q <= `SPKBYP_RDATA_RESET;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign rdata_o = rdata_q;
  assign rvalid_o = rvalid_q;
  assign left_gain_code_o = amp_q[`SPKBYP_AMP_LGAIN_HI:`SPKBYP_AMP_LGAIN_LO];
  assign right_gain_code_o = amp_q[`SPKBYP_AMP_RGAIN_HI:`SPKBYP_AMP_RGAIN_LO];
  assign left_amp_en_o = amp_q[`SPKBYP_AMP_LEN_BIT];
  assign right_amp_en_o = amp_q[`SPKBYP_AMP_REN_BIT];
  assign bypass_sw_en_o = amp_q[`SPKBYP_AMP_BYP_BIT];
  assign boot_clk_en_o = amp_q[`SPKBYP_AMP_BOOT_BIT];

  spkbyp_gain_dec u_lgain (
    .code_i(amp_q[`SPKBYP_AMP_LGAIN_HI:`SPKBYP_AMP_LGAIN_LO]),
    .gain_db_o(left_gain_db_o)
  );
  spkbyp_gain_dec u_rgain (
    .code_i(amp_q[`SPKBYP_AMP_RGAIN_HI:`SPKBYP_AMP_RGAIN_LO]),
    .gain_db_o(right_gain_db_o)
  );
  spkbyp_dith_dec u_ldith (
    .code_i(dith_q[`SPKBYP_DITH_L_HI:`SPKBYP_DITH_L_LO]),
    .enable_o(left_dith_en_o),
    .negative_o(left_dith_neg_o),
    .mag_mv_o(left_dith_mv_o)
  );
  spkbyp_dith_dec u_rdith (
    .code_i(dith_q[`SPKBYP_DITH_R_HI:`SPKBYP_DITH_R_LO]),
    .enable_o(right_dith_en_o),
    .negative_o(right_dith_neg_o),
    .mag_mv_o(right_dith_mv_o)
  );

  sequence s_amp_write;
    wr_en_i && addr_i == `SPKBYP_ADDR_AMP_CTRL;
  endsequence

  sequence s_dith_write;
    wr_en_i && addr_i == `SPKBYP_ADDR_DITHER;
  endsequence

  sequence s_amp_read;
    rd_en_i && addr_i == `SPKBYP_ADDR_AMP_CTRL;
  endsequence

  sequence s_dith_read;
    rd_en_i && addr_i == `SPKBYP_ADDR_DITHER;
  endsequence

  sequence s_no_amp_write;
    !(wr_en_i && addr_i == `SPKBYP_ADDR_AMP_CTRL);
  endsequence

  sequence s_no_dith_write;
    !(wr_en_i && addr_i == `SPKBYP_ADDR_DITHER);
  endsequence

  chk_left_gain_db: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    s_amp_write |=> left_gain_db_o == 5'(6 * int'($past(wdata_i[7:6]))))
    else $error("left gain mismatch");
  chk_right_gain_db: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    s_amp_write |=> right_gain_db_o == 5'(6 * int'($past(wdata_i[5:4]))))
    else $error("right gain mismatch");
  chk_left_enable: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    s_amp_write |=> left_amp_en_o == $past(wdata_i[3]))
    else $error("left enable mismatch");
  chk_right_enable: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    s_amp_write |=> right_amp_en_o == $past(wdata_i[2]))
    else $error("right enable mismatch");
  chk_bypass_switch: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    s_amp_write |=> bypass_sw_en_o == $past(wdata_i[1]))
    else $error("bypass mismatch");
  chk_boot_clock_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    s_no_amp_write |=> $stable(boot_clk_en_o))
    else $error("boot clock changed without write");
  chk_reset_amp_zero: assert property (@(posedge ref_clk_i)
    rst_i |=> !left_amp_en_o && !right_amp_en_o && !bypass_sw_en_o && !boot_clk_en_o
      && left_gain_db_o == 5'h00 && right_gain_db_o == 5'h00)
    else $error("amp not zero after reset");
  chk_left_dither: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    s_dith_write |=> left_dith_mv_o == 8'(15 * int'($past(wdata_i[6:4])))
      && left_dith_neg_o == ($past(wdata_i[7]) && $past(wdata_i[6:4]) != 3'h0))
    else $error("left dither mismatch");
  chk_right_dither: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    s_dith_write |=> right_dith_en_o == ($past(wdata_i[2:0]) != 3'h0))
    else $error("right dither mismatch");
  chk_dither_extremes: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    left_dith_en_o |-> left_dith_mv_o >= 8'h0F && left_dith_mv_o <= 8'h69)
    else $error("dither magnitude out of range");
  chk_reserved_zero: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    rd_en_i && addr_i != `SPKBYP_ADDR_AMP_CTRL && addr_i != `SPKBYP_ADDR_DITHER |=> rvalid_o && rdata_o == 8'h00)
    else $error("reserved read not zero");
  chk_wo_readback: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    rd_en_i && addr_i == `SPKBYP_ADDR_AMP_CTRL |=> rdata_o[3:1] == 3'h0)
    else $error("write-only bits leaked on read");

  // Stored controls follow writes and hold otherwise
  chk_amp_write_stores: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    s_amp_write
    |=> amp_q == $past(wdata_i))
    else $error("amp write not stored");
  chk_dith_write_stores: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    s_dith_write
    |=> dith_q == $past(wdata_i))
    else $error("dither write not stored");
  chk_left_gain_code: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    s_amp_write
    |=> left_gain_code_o == $past(wdata_i[7:6]))
    else $error("left gain code mismatch");
  chk_right_gain_code: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    s_amp_write
    |=> right_gain_code_o == $past(wdata_i[5:4]))
    else $error("right gain code mismatch");
  chk_left_gain_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    s_no_amp_write
    |=> $stable(left_gain_code_o))
    else $error("left gain changed without write");
  chk_right_gain_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    s_no_amp_write
    |=> $stable(right_gain_code_o))
    else $error("right gain changed without write");
  chk_left_en_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    s_no_amp_write
    |=> $stable(left_amp_en_o))
    else $error("left enable changed without write");
  chk_right_en_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    s_no_amp_write
    |=> $stable(right_amp_en_o))
    else $error("right enable changed without write");
  chk_bypass_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    s_no_amp_write
    |=> $stable(bypass_sw_en_o))
    else $error("bypass changed without write");
  chk_boot_clock_write: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    s_amp_write
    |=> boot_clk_en_o == $past(wdata_i[0]))
    else $error("boot clock enable mismatch");
  chk_dith_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    s_no_dith_write
    |=> $stable(dith_q))
    else $error("dither changed without write");

  // Dither decode
  chk_left_dither_en: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    s_dith_write
    |=> left_dith_en_o == ($past(wdata_i[6:4]) != 3'h0))
    else $error("left dither enable mismatch");
  chk_right_dither_mv: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    s_dith_write
    |=> right_dith_mv_o == 8'(15 * int'($past(wdata_i[2:0]))))
    else $error("right dither magnitude mismatch");
  chk_right_dither_neg: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    s_dith_write
    |=> right_dith_neg_o == ($past(wdata_i[3]) && $past(wdata_i[2:0]) != 3'h0))
    else $error("right dither sign mismatch");
  chk_left_dither_off: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !left_dith_en_o
    |-> left_dith_mv_o == 8'h00 && !left_dith_neg_o)
    else $error("left dither active while off");
  chk_right_dither_off: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !right_dith_en_o
    |-> right_dith_mv_o == 8'h00 && !right_dith_neg_o)
    else $error("right dither active while off");
  chk_left_max_mag: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    dith_q[6:4] == 3'h7
    |-> left_dith_mv_o == `SPKBYP_DITH_MAX_MV)
    else $error("left dither maximum wrong");
  chk_left_min_mag: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    dith_q[6:4] == 3'h1
    |-> left_dith_mv_o == `SPKBYP_DITH_MIN_MV)
    else $error("left dither minimum wrong");
  chk_right_max_mag: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    dith_q[2:0] == 3'h7
    |-> right_dith_mv_o == `SPKBYP_DITH_MAX_MV)
    else $error("right dither maximum wrong");
  chk_right_min_mag: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    dith_q[2:0] == 3'h1
    |-> right_dith_mv_o == `SPKBYP_DITH_MIN_MV)
    else $error("right dither minimum wrong");
  chk_right_dither_range: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    right_dith_en_o
    |-> right_dith_mv_o >= `SPKBYP_DITH_MIN_MV && right_dith_mv_o <= `SPKBYP_DITH_MAX_MV)
    else $error("right dither magnitude out of range");

  // Read path and reset
  chk_boot_readback: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    s_amp_read
    |=> rdata_o[0] == $past(boot_clk_en_o))
    else $error("boot clock readback mismatch");
  chk_gain_readback: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    s_amp_read
    |=> rdata_o[7:4] == $past({left_gain_code_o, right_gain_code_o}))
    else $error("gain readback mismatch");
  chk_dith_readback: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    s_dith_read
    |=> rdata_o == $past(dith_q))
    else $error("dither readback mismatch");
  chk_rvalid_after_read: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    rd_en_i
    |=> rvalid_o)
    else $error("read not answered");
  chk_rvalid_idle_low: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !rd_en_i
    |=> !rvalid_o)
    else $error("read valid without read");
  chk_rdata_idle_zero: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !rd_en_i
    |=> rdata_o == 8'h00)
    else $error("read data not zero when idle");
  chk_reset_dither_zero: assert property (@(posedge ref_clk_i)
    rst_i
    |=> dith_q == `SPKBYP_DITH_RESET && !left_dith_en_o && !right_dith_en_o)
    else $error("dither not zero after reset");
  chk_reset_read_idle: assert property (@(posedge ref_clk_i)
    rst_i
    |=> !rvalid_o && rdata_o == 8'h00)
    else $error("read path not idle after reset");
endmodule : spkbyp_regs
`default_nettype wire

// ### tb/spkbyp_host.sv
`timescale 1ns/1ps
`default_nettype none
module spkbyp_host
  import spkbyp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rvalid_i,
  input wire spkbyp_byte_t rdata_i,
  output logic wr_en_o,
  output logic rd_en_o,
  output spkbyp_byte_t addr_o,
  output spkbyp_byte_t wdata_o
);
  initial begin
    wr_en_o = 1'b0;
    rd_en_o = 1'b0;
    addr_o = 8'h00;
    wdata_o = 8'h00;
  end
  task automatic wr(input spkbyp_byte_t a, input spkbyp_byte_t d);
    if (a == 8'h49 || a == 8'h4C) begin
      @(posedge clk_i);
      wr_en_o <= 1'b1;
      addr_o <= a;
      wdata_o <= d;
      @(posedge clk_i);
      wr_en_o <= 1'b0;
      wdata_o <= ~d;
    end
  endtask : wr
  task automatic rd(input spkbyp_byte_t a, output spkbyp_byte_t d, output bit ok);
    ok = 1'b0;
    d = 8'h00;
    @(posedge clk_i);
    rd_en_o <= 1'b1;
    addr_o <= a;
    @(posedge clk_i);
    rd_en_o <= 1'b0;
    addr_o <= ~a;
    for (int i = 0; i < 4 && !ok; i++) begin
      #1;
      if (rvalid_i === 1'b1) begin
        ok = 1'b1;
        d = rdata_i;
      end else @(posedge clk_i);
    end
  endtask : rd
endmodule : spkbyp_host
`default_nettype wire

// ### tb/test_speaker_bypass_dither_regs.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_total++; \
  $display("ERROR %0t got %h exp %h", $time, a, b); end end
module test_speaker_bypass_dither_regs
  import spkbyp_pkg::*;
;
  logic ref_clk_i = 1'b0, rst_i = 1'b1, wr_en_i, rd_en_i, rvalid_o, left_amp_en_o, right_amp_en_o;
  logic bypass_sw_en_o, boot_clk_en_o, left_dith_en_o, left_dith_neg_o, right_dith_en_o, right_dith_neg_o;
  spkbyp_byte_t addr_i, wdata_i, rdata_o;
  logic [4:0] left_gain_db_o, right_gain_db_o;
  spkbyp_gain_t left_gain_code_o, right_gain_code_o;
  spkbyp_mv_t left_dith_mv_o, right_dith_mv_o;
  int err_total = 0;
  int comparisons = 0;
  spkbyp_regs u_dut (.ref_clk_i, .rst_i, .wr_en_i, .rd_en_i, .addr_i, .wdata_i, .rdata_o, .rvalid_o,
    .left_gain_db_o, .right_gain_db_o, .left_gain_code_o, .right_gain_code_o, .left_amp_en_o,
    .right_amp_en_o, .bypass_sw_en_o, .boot_clk_en_o, .left_dith_en_o, .left_dith_neg_o,
    .left_dith_mv_o, .right_dith_en_o, .right_dith_neg_o, .right_dith_mv_o);
  spkbyp_host u_host (.clk_i(ref_clk_i), .rvalid_i(rvalid_o), .rdata_i(rdata_o), .wr_en_o(wr_en_i),
    .rd_en_o(rd_en_i), .addr_o(addr_i), .wdata_o(wdata_i));
  task automatic conclude();
    $display("comparisons %0d errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude
  task automatic rd(input spkbyp_byte_t a, output spkbyp_byte_t d);
    bit ok;
    u_host.rd(a, d, ok);
    if (!ok) begin
      err_total++;
      conclude();
    end
  endtask : rd
  function automatic logic [9:0] exp_dith(input logic [3:0] c);
    logic en;
    en = c[2:0] != 3'h0;
    return {en, en & c[3], 8'(c[2:0] * 15)};
  endfunction : exp_dith
  task automatic t_reset();
    spkbyp_byte_t d;
    if (rst_i !== 1'b1) @(posedge ref_clk_i);
    rst_i <= 1'b1;
    repeat (16) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    #1;
    `CHK({left_gain_code_o, right_gain_code_o, left_gain_db_o, right_gain_db_o, left_amp_en_o, right_amp_en_o,
      bypass_sw_en_o, boot_clk_en_o, left_dith_en_o, left_dith_neg_o, left_dith_mv_o, right_dith_en_o,
      right_dith_neg_o, right_dith_mv_o, rvalid_o}, 39'h0)
    rd(8'h49, d);
    `CHK(d, 8'h00)
    rd(8'h4C, d);
    `CHK(d, 8'h00)
    $display("reset test done");
  endtask : t_reset
  task automatic t_rsvd();
    spkbyp_byte_t a[8] = '{8'h46, 8'h47, 8'h48, 8'h4A, 8'h4B, 8'h4D, 8'h4E, 8'h50};
    spkbyp_byte_t d;
    foreach (a[k]) begin
      rd(a[k], d);
      `CHK(d, 8'h00)
    end
    $display("reserved test done");
  endtask : t_rsvd
  task automatic t_amp();
    spkbyp_byte_t w, d;
    for (int i = 0; i < 4; i++) begin
      w = {i[1:0], 2'(3 - i), i[0], ~i[0], i[1], ~i[1]};
      u_host.wr(8'h49, w);
      #1;
      `CHK({left_gain_code_o, right_gain_code_o}, w[7:4])
      `CHK({left_gain_db_o, right_gain_db_o}, {5'(i * 6), 5'((3 - i) * 6)})
      rd(8'h49, d);
      `CHK({left_amp_en_o, right_amp_en_o, bypass_sw_en_o, boot_clk_en_o}, w[3:0])
      `CHK(d, {w[7:4], 3'h0, w[0]})
    end
    $display("amp test done");
  endtask : t_amp
  task automatic t_dith();
    spkbyp_byte_t d;
    logic [3:0] c;
    for (int i = 0; i < 16; i++) begin
      c = 4'(i);
      u_host.wr(8'h4C, {c, ~c});
      #1;
      `CHK({left_dith_en_o, left_dith_neg_o, left_dith_mv_o}, exp_dith(c))
      `CHK({right_dith_en_o, right_dith_neg_o, right_dith_mv_o}, exp_dith(~c))
      rd(8'h4C, d);
      `CHK(d, {c, ~c})
    end
    $display("dither test done");
  endtask : t_dith
  initial begin
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    t_reset();
    t_rsvd();
    t_amp();
    t_dith();
    t_reset();
    conclude();
  end
endmodule : test_speaker_bypass_dither_regs
`default_nettype wire
